// ### common/spc_pkg.sv
// System power and clock control: shared constants and types.
// Assumes a single 40 MHz bus clock that keeps running in power-down.
package spc_pkg;
    localparam int          CLK_HZ       = 40000000;
    localparam int          NUM_PINS     = 9;
    localparam int          NUM_LINES    = 4;
    localparam int          NUM_PERIPH   = 16;
    // Wake-up timer: oscillator settle time in microseconds
    localparam int          WAKE_US      = 100;
    localparam int          WAKE_CYC     = (WAKE_US * (CLK_HZ / 1000000));

    // Register byte offsets
    localparam logic [7:0]  OFS_PWR_CTRL = 8'h00;
    localparam logic [7:0]  OFS_PCLK_DIV = 8'h04;
    localparam logic [7:0]  OFS_VEC_MAP  = 8'h08;
    localparam logic [7:0]  OFS_EX_MODE  = 8'h0C;
    localparam logic [7:0]  OFS_EX_FLAG  = 8'h10;
    localparam logic [7:0]  OFS_EX_WAKE  = 8'h14;
    localparam logic [7:0]  OFS_EX_SEL   = 8'h18;
    localparam logic [7:0]  OFS_PER_EN   = 8'h1C;
    localparam logic [7:0]  OFS_STATUS   = 8'h20;

    // Field positions
    localparam int          PWR_IDLE_BIT = 0;
    localparam int          PWR_DOWN_BIT = 1;
    localparam int          ST_LVL_LSB   = 0;
    localparam int          ST_VLD_BIT   = 2;
    localparam int          ST_STATE_LSB = 4;
    localparam int          ST_RATIO_LSB = 8;

    // Reset values
    localparam logic [1:0]  RST_DIV      = 2'h0;
    localparam logic [17:0] RST_EX_SEL   = 18'h0E4E4;
    localparam logic [15:0] RST_PER_EN   = 16'hFFFF;

    // Protection patterns stored in flash
    localparam logic [31:0] PAT_LVL1     = 32'h12345678;
    localparam logic [31:0] PAT_LVL2     = 32'h87654321;
    localparam logic [31:0] PAT_LVL3     = 32'h43218765;

    typedef enum logic [1:0] {
        DIV_QUARTER = 2'b00,
        DIV_FULL    = 2'b01,
        DIV_HALF    = 2'b10
    } spc_div_t;

    typedef enum logic [1:0] {
        PROT_NONE = 2'b00,
        PROT_ONE  = 2'b01,
        PROT_TWO  = 2'b10,
        PROT_THREE = 2'b11
    } spc_prot_t;

    typedef enum logic [1:0] {
        PM_RUN   = 2'b00,
        PM_IDLE  = 2'b01,
        PM_DOWN  = 2'b10,
        PM_WAKE  = 2'b11
    } spc_pm_t;
endpackage

// ### common/spc_div_if.sv
// Link between the control core and the peripheral clock divider.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
interface spc_div_if;
    logic [1:0] req_ratio;
    logic       run;
    logic       pclk_en;
    logic [1:0] act_ratio;
    modport ctl (output req_ratio, output run, input pclk_en, input act_ratio);
    modport div (input req_ratio, input run, output pclk_en, output act_ratio);
endinterface

// ### verilog/spc_pclk_div.sv
// Peripheral clock divider: one-cycle enable at full, half or quarter rate.
// Assumes the requested ratio comes from logic on the same clock.
`timescale 1ns/1ps
module spc_pclk_div
    import spc_pkg::*;
(
    input  wire logic hclk,     // Core clock
    input  wire logic hresetn,  // Async reset, active low
    spc_div_if.div    dv        // Ratio in, enable out
);
    typedef struct packed {
        logic [1:0] cnt;
        logic [1:0] ratio;
    } spc_div_st_t;

    spc_div_st_t st_ff;
    spc_div_st_t nxt_st;
    logic [1:0]  period_m1;

    always_comb begin
        nxt_st = st_ff;
        period_m1 = 2'h3;
        case (dv.req_ratio)
            DIV_FULL: period_m1 = 2'h0;
            DIV_HALF: period_m1 = 2'h1;
            default:  period_m1 = 2'h3;
        endcase
        if (dv.run) begin
            if (st_ff.cnt == 2'h0) begin
                // New ratio only at a period boundary, so no pulse is shortened
                nxt_st.ratio = dv.req_ratio;
                nxt_st.cnt   = period_m1;
            end else begin
                nxt_st.cnt = st_ff.cnt - 2'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{cnt: 2'h0, ratio: RST_DIV};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dv.pclk_en   = dv.run && (st_ff.cnt == 2'h0);
    assign dv.act_ratio = st_ff.ratio;
endmodule

// ### verilog/spc_top.sv
// System power and clock control with AHB-Lite register slave.
// Assumes hclk is the always-on clock; gating cells outside take the
// registered enables. Flash controller delivers the protection word.
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module spc_top
    import spc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input  wire logic                  hclk,          // Core clock
    input  wire logic                  hresetn,       // Async reset, active low
    input  wire logic                  hsel,          // Slave select
    input  wire logic [31:0]           haddr,         // Byte address
    input  wire logic [1:0]            htrans,        // Transfer type
    input  wire logic                  hwrite,        // Write when high
    input  wire logic [2:0]            hsize,         // Transfer size
    input  wire logic [31:0]           hwdata,        // Write data
    input  wire logic                  hready,        // Bus ready in
    output logic [31:0]                hrdata,        // Read data
    output logic                       hreadyout,     // Always ready
    output logic                       hresp,         // Always OKAY
    input  wire logic [NUM_PINS-1:0]   ext_pin,       // External interrupt pins
    input  wire logic                  boot_override_pin, // Low forces serial boot
    input  wire logic                  irq_pending,   // Any interrupt from controller
    input  wire logic                  pll_running,   // Multiplier is locked and used
    input  wire logic                  flash_init_done, // Protection word valid
    input  wire logic [31:0]           prot_word,     // Word read from flash
    output logic [NUM_LINES-1:0]       ext_irq,       // Four interrupt requests
    output logic                       core_clk_en,   // Core, memory, bus clocks
    output logic [NUM_PERIPH-1:0]      periph_clk_en, // Per-peripheral enables
    output logic                       pclk_en,       // Peripheral clock tick
    output logic                       osc_en,        // Oscillator enable
    output logic                       pll_keep,      // Keep multiplier running
    output logic                       pin_hold,      // Freeze output pins
    output logic                       vec_in_ram,    // Vectors from RAM
    output logic                       debug_enable,  // Debug port allowed
    output logic                       serial_boot_programming, // Serial path allowed
    output logic                       serial_cmd_limited, // Restricted command set
    output logic                       sector0_locked,  // Sector zero not writable
    output logic                       full_erase_only, // Only chip erase first
    output logic                       boot_override_en, // Pin may force serial boot
    output logic                       serial_boot_req,  // Enter serial boot now
    output logic                       in_application_programming // Always allowed
);
    typedef struct packed {
        logic                  ap_vld;
        logic                  ap_wr;
        logic [7:0]            ap_ofs;
        logic [31:0]           rdata;
        logic [1:0]            pwr;
        logic [1:0]            div;
        logic                  vmap;
        logic [NUM_LINES-1:0]  mode;
        logic [NUM_LINES-1:0]  flag;
        logic [NUM_LINES-1:0]  wake;
        logic [17:0]           sel;
        logic [NUM_PERIPH-1:0] per_en;
        logic [NUM_PINS-1:0]   pin_s1;
        logic [NUM_PINS-1:0]   pin_s2;
        logic                  boot_s1;
        logic                  boot_s2;
        logic [NUM_LINES-1:0]  line_prev;
        logic [NUM_LINES-1:0]  irq;
        spc_prot_t             lvl;
        logic                  lvl_vld;
        spc_pm_t               pm;
        logic [15:0]           wcnt;
        logic                  core_en;
        logic [NUM_PERIPH-1:0] per_out;
        logic                  osc;
        logic                  hold;
    } spc_state_t;

    spc_state_t             st_ff;
    spc_state_t             nxt_st;
    logic [NUM_LINES-1:0]   line_lvl;
    logic [NUM_LINES-1:0]   line_rise;
    logic [NUM_LINES-1:0]   irq_now;
    logic                   wr_en;
    logic [1:0]             pin_line;
    logic                   prot_three;

    spc_div_if div_bus();

    spc_pclk_div u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .dv      (div_bus)
    );

    always_comb begin
        nxt_st    = st_ff;
        line_lvl  = '0;
        line_rise = '0;
        irq_now   = '0;
        wr_en     = 1'b0;
        pin_line  = 2'h0;

        // Pin synchronisers; only the second stage is used
        nxt_st.pin_s1  = ext_pin;
        nxt_st.pin_s2  = st_ff.pin_s1;
        nxt_st.boot_s1 = boot_override_pin;
        nxt_st.boot_s2 = st_ff.boot_s1;

        // Each pin is steered onto one of the four request lines
        for (int p = 0; p < NUM_PINS; p++) begin
            pin_line = st_ff.sel[(p % 9) * 2 +: 2];
            if (st_ff.pin_s2[p]) begin
                line_lvl[pin_line] = 1'b1;
            end
        end
        nxt_st.line_prev = line_lvl;
        line_rise = line_lvl & ~st_ff.line_prev;

        // Bus write lands in the data phase; a new event beats a clear
        wr_en = st_ff.ap_vld && st_ff.ap_wr;
        if (wr_en) begin
            case (st_ff.ap_ofs)
                OFS_PWR_CTRL: nxt_st.pwr    = hwdata[1:0];
                OFS_PCLK_DIV: nxt_st.div    = hwdata[1:0];
                OFS_VEC_MAP:  nxt_st.vmap   = hwdata[0];
                OFS_EX_MODE:  nxt_st.mode   = hwdata[NUM_LINES-1:0];
                OFS_EX_FLAG:  nxt_st.flag   = st_ff.flag & ~hwdata[NUM_LINES-1:0];
                OFS_EX_WAKE:  nxt_st.wake   = hwdata[NUM_LINES-1:0];
                OFS_EX_SEL:   nxt_st.sel    = hwdata[17:0];
                OFS_PER_EN:   nxt_st.per_en = hwdata[NUM_PERIPH-1:0];
                default:      nxt_st.pwr    = st_ff.pwr;
            endcase
        end
        nxt_st.flag = nxt_st.flag | (line_rise & st_ff.mode);

        for (int l = 0; l < NUM_LINES; l++) begin
            irq_now[l] = st_ff.mode[l] ? st_ff.flag[l] : line_lvl[l];
        end
        nxt_st.irq = irq_now;

        // Protection word is taken once, when flash is ready
        if (!st_ff.lvl_vld && flash_init_done) begin
            nxt_st.lvl_vld = 1'b1;
            case (prot_word)
                PAT_LVL1: nxt_st.lvl = PROT_ONE;
                PAT_LVL2: nxt_st.lvl = PROT_TWO;
                PAT_LVL3: nxt_st.lvl = PROT_THREE;
                default:  nxt_st.lvl = PROT_NONE;
            endcase
        end

        // Power mode sequencer
        case (st_ff.pm)
            PM_RUN: begin
                if (st_ff.pwr[PWR_DOWN_BIT]) begin
                    nxt_st.pm = PM_DOWN;
                end else if (st_ff.pwr[PWR_IDLE_BIT]) begin
                    nxt_st.pm = PM_IDLE;
                end
            end
            PM_IDLE: begin
                if (irq_pending || (|irq_now)) begin
                    nxt_st.pm  = PM_RUN;
                    nxt_st.pwr = 2'h0;
                end
            end
            PM_DOWN: begin
                // Only clockless sources end power-down
                if (|(irq_now & st_ff.wake)) begin
                    nxt_st.pm   = PM_WAKE;
                    nxt_st.wcnt = 16'(WAKE_CYCLES - 1);
                end
            end
            PM_WAKE: begin
                if (st_ff.wcnt == 16'h0) begin
                    nxt_st.pm  = PM_RUN;
                    nxt_st.pwr = 2'h0;
                end else begin
                    nxt_st.wcnt = st_ff.wcnt - 16'h1;
                end
            end
            default: nxt_st.pm = PM_RUN;
        endcase

        // Enables are flopped so downstream gating cells see clean levels
        nxt_st.core_en = (nxt_st.pm == PM_RUN);
        nxt_st.osc     = (nxt_st.pm != PM_DOWN);
        nxt_st.hold    = (nxt_st.pm == PM_DOWN) || (nxt_st.pm == PM_WAKE);
        nxt_st.per_out = nxt_st.osc && (nxt_st.pm != PM_WAKE)
                         ? nxt_st.per_en : '0;

        // Address phase capture
        nxt_st.ap_vld = 1'b0;
        if (hsel && hready && htrans[1]) begin
            nxt_st.ap_vld = 1'b1;
            // Writes outside the register page are dropped rather than aliased
            nxt_st.ap_wr  = hwrite && (haddr[31:8] == 24'h0);
            nxt_st.ap_ofs = haddr[7:0];
            // Read from next values, status excepted, so a write just before is seen
            nxt_st.rdata = 32'h0;
            if (!hwrite && (haddr[31:8] == 24'h0)) begin
                case (haddr[7:0])
                    OFS_PWR_CTRL: nxt_st.rdata[1:0] = nxt_st.pwr;
                    OFS_PCLK_DIV: nxt_st.rdata[1:0] = nxt_st.div;
                    OFS_VEC_MAP:  nxt_st.rdata[0]   = nxt_st.vmap;
                    OFS_EX_MODE:  nxt_st.rdata[NUM_LINES-1:0] = nxt_st.mode;
                    OFS_EX_FLAG:  nxt_st.rdata[NUM_LINES-1:0] = nxt_st.flag;
                    OFS_EX_WAKE:  nxt_st.rdata[NUM_LINES-1:0] = nxt_st.wake;
                    OFS_EX_SEL:   nxt_st.rdata[17:0] = nxt_st.sel;
                    OFS_PER_EN:   nxt_st.rdata[NUM_PERIPH-1:0] = nxt_st.per_en;
                    OFS_STATUS: begin
                        nxt_st.rdata[ST_LVL_LSB +: 2]   = st_ff.lvl;
                        nxt_st.rdata[ST_VLD_BIT]        = st_ff.lvl_vld;
                        nxt_st.rdata[ST_STATE_LSB +: 2] = st_ff.pm;
                        nxt_st.rdata[ST_RATIO_LSB +: 2] = div_bus.act_ratio;
                    end
                    default: nxt_st.rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff         <= '0;
            st_ff.div     <= RST_DIV;
            st_ff.sel     <= RST_EX_SEL;
            st_ff.per_en  <= RST_PER_EN;
            st_ff.per_out <= RST_PER_EN;
            st_ff.core_en <= 1'b1;
            st_ff.osc     <= 1'b1;
            st_ff.pm      <= PM_RUN;
            st_ff.lvl     <= PROT_NONE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Divider keeps ticking in idle; it stops with the oscillator and during the wake-up wait
    assign div_bus.req_ratio = st_ff.div;
    assign div_bus.run       = st_ff.osc && (st_ff.pm != PM_WAKE);

    assign prot_three = (st_ff.lvl == PROT_THREE);

    assign hrdata        = st_ff.rdata;
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign ext_irq       = st_ff.irq;
    assign core_clk_en   = st_ff.core_en;
    assign periph_clk_en = st_ff.per_out;
    assign pclk_en       = div_bus.pclk_en;
    assign osc_en        = st_ff.osc;
    assign pll_keep      = pll_running && st_ff.osc;
    assign pin_hold      = st_ff.hold;
    assign vec_in_ram    = st_ff.vmap;

    // Until the word is read, hold debug and serial access shut
    assign debug_enable  = st_ff.lvl_vld && (st_ff.lvl == PROT_NONE);
    assign serial_boot_programming = st_ff.lvl_vld && !prot_three;
    assign serial_cmd_limited = (st_ff.lvl == PROT_ONE)
                                || (st_ff.lvl == PROT_TWO);
    assign sector0_locked  = (st_ff.lvl == PROT_ONE);
    assign full_erase_only = (st_ff.lvl == PROT_TWO);
    assign boot_override_en = st_ff.lvl_vld && !prot_three;
    assign serial_boot_req = boot_override_en && !st_ff.boot_s2;
    assign in_application_programming = 1'b1;
endmodule

// ### verification/spc_core_model.sv
// Processor-side register bus master: single whole-word transfers.
// Assumes hready is the slave's hreadyout and hclk runs freely.
`timescale 1ns/1ps
module spc_core_model (
    input  wire logic        hclk,   // Core clock
    input  wire logic        hready, // Slave ready
    input  wire logic [31:0] hrdata, // Read data
    output logic             hsel,   // Select
    output logic [31:0]      haddr,  // Byte address
    output logic [1:0]       htrans, // Transfer type
    output logic             hwrite, // Write when high
    output logic [2:0]       hsize,  // Word size
    output logic [31:0]      hwdata  // Write data
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Address phase held until ready is seen, then data phase likewise
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule

// ### verification/spc_top_chk.sv
// Concurrent checks on the power, clock and protection outputs.
// Assumes the bind below and a short wake-up count in simulation.
`timescale 1ns/1ps
module spc_top_chk
    import spc_pkg::*;
#(
    parameter int WAKE_CYCLES = 8
) (
    input wire logic        hclk,                      // Clock
    input wire logic        hresetn,                   // Reset
    input wire logic        irq_pending,               // Idle wake
    input wire logic        pll_running,               // Multiplier on
    input wire logic        core_clk_en,               // Core clocks
    input wire logic [15:0] periph_clk_en,             // Peripheral clocks
    input wire logic        osc_en,                    // Oscillator
    input wire logic        pll_keep,                  // Keep multiplier
    input wire logic        pin_hold,                  // Pins frozen
    input wire logic        debug_enable,              // Debug allowed
    input wire logic        serial_boot_programming,   // Serial allowed
    input wire logic        serial_cmd_limited,        // Reduced commands
    input wire logic        sector0_locked,            // Sector zero locked
    input wire logic        full_erase_only,           // Erase first
    input wire logic        boot_override_en,          // Pin may force boot
    input wire logic        serial_boot_req,           // Boot request
    input wire logic        in_application_programming // Calls allowed
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Counts the oscillator settle wait between power-down and run
    logic [15:0] wait_cnt_ff;
    logic [15:0] nxt_wait_cnt;
    always_comb nxt_wait_cnt = (osc_en && pin_hold) ? wait_cnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wait_cnt_ff <= 16'h0000;
        else wait_cnt_ff <= nxt_wait_cnt;
    end

    property p_iap; in_application_programming; endproperty
    a_iap: assert property (p_iap) else $error("programming calls blocked");
    property p_down; !osc_en |-> !core_clk_en && pin_hold && periph_clk_en == 16'h0000; endproperty
    a_down: assert property (p_down) else $error("clocks alive in power-down");
    property p_hold; pin_hold |-> !core_clk_en; endproperty
    a_hold: assert property (p_hold) else $error("core runs with pins frozen");
    property p_pll; pll_keep == (pll_running && osc_en); endproperty
    a_pll: assert property (p_pll) else $error("multiplier keep wrong");
    property p_open;
        debug_enable |-> serial_boot_programming && !serial_cmd_limited
                         && !sector0_locked && !full_erase_only;
    endproperty
    a_open: assert property (p_open) else $error("open level restricted");
    property p_lvl1; sector0_locked |-> !debug_enable && serial_cmd_limited; endproperty
    a_lvl1: assert property (p_lvl1) else $error("level one access wrong");
    property p_lvl2;
        full_erase_only |-> !debug_enable && serial_cmd_limited && !sector0_locked;
    endproperty
    a_lvl2: assert property (p_lvl2) else $error("level two access wrong");
    property p_lvl3; !serial_boot_programming |-> !debug_enable; endproperty
    a_lvl3: assert property (p_lvl3) else $error("debug open with serial shut");
    property p_boot; !boot_override_en |-> !serial_boot_req; endproperty
    a_boot: assert property (p_boot) else $error("boot pin obeyed while disabled");
    property p_idle; !core_clk_en && !pin_hold && irq_pending |-> ##[1:2] core_clk_en; endproperty
    a_idle: assert property (p_idle) else $error("idle not ended by interrupt");
    property p_wake;
        $fell(pin_hold) |-> core_clk_en && wait_cnt_ff >= WAKE_CYCLES - 1
                            && wait_cnt_ff <= WAKE_CYCLES + 1;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up wait length wrong");
endmodule

bind spc_top spc_top_chk #(.WAKE_CYCLES(WAKE_CYCLES)) spc_top_chk_inst (
    .hclk, .hresetn, .irq_pending, .pll_running, .core_clk_en, .periph_clk_en, .osc_en,
    .pll_keep, .pin_hold, .debug_enable, .serial_boot_programming, .serial_cmd_limited,
    .sector0_locked, .full_erase_only, .boot_override_en, .serial_boot_req,
    .in_application_programming
);

// ### verification/spc_top_tb.sv
// Bench: protection levels, divider, register map, idle and power-down.
// Assumes the core model as the only bus master and a short wake-up count.
`timescale 1ns/1ps
module spc_top_tb
    import spc_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } spc_row_t;
    localparam int          WK = 8;
    localparam logic [31:0] PATS [4] = '{PAT_LVL1 ^ 32'h1, PAT_LVL1, PAT_LVL2, PAT_LVL3};
    localparam logic [5:0]  EXPS [4] = '{6'h31, 6'h1D, 6'h1B, 6'h00};
    localparam int          RATS [3] = '{40, 20, 10};
    localparam spc_row_t    ROWS [9] = '{
        '{1'b0, OFS_PWR_CTRL, 32'h0, 32'h0}, '{1'b0, OFS_PCLK_DIV, 32'h0, 32'h3},
        '{1'b0, OFS_EX_SEL, 32'h0, 32'h0000E4E4}, '{1'b0, OFS_PER_EN, 32'h0, 32'h0000FFFF},
        '{1'b1, 8'h24, 32'hDEADBEEF, 32'h0}, '{1'b1, OFS_PER_EN, 32'hFFFF00A5, 32'hA5},
        '{1'b1, OFS_EX_MODE, 32'h1F, 32'hF}, '{1'b1, OFS_EX_WAKE, 32'h1, 32'h1},
        '{1'b1, OFS_VEC_MAP, 32'h1, 32'h1}};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        irq_pending = 1'b0;
    logic        pll_running = 1'b1;
    logic        flash_init_done = 1'b0;
    logic        boot_override_pin = 1'b1;
    logic [8:0]  ext_pin = 9'h000;
    logic [31:0] prot_word = 32'h0;
    logic        hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, c;
    logic [3:0]  ext_irq;
    logic [15:0] periph_clk_en;
    logic        core_clk_en, pclk_en, osc_en, pll_keep, pin_hold, vec_in_ram;
    logic        debug_enable, serial_boot_programming, serial_cmd_limited, sector0_locked;
    logic        full_erase_only, boot_override_en, serial_boot_req, in_application_programming;
    int          mismatches = 0;
    int          tests_run = 0;
    int          n;

    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;

    spc_core_model spc_core_model_inst (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
                                        .hwrite, .hsize, .hwdata);
    spc_top #(.WAKE_CYCLES(WK)) spc_top_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .ext_pin, .boot_override_pin, .irq_pending, .pll_running,
        .flash_init_done, .prot_word, .ext_irq, .core_clk_en, .periph_clk_en, .pclk_en,
        .osc_en, .pll_keep, .pin_hold, .vec_in_ram, .debug_enable, .serial_boot_programming,
        .serial_cmd_limited, .sector0_locked, .full_erase_only, .boot_override_en,
        .serial_boot_req, .in_application_programming
    );

    task automatic chk_out(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        spc_core_model_inst.xfer(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        spc_core_model_inst.xfer(1'b0, a, 32'h0, r);
        chk_out(nm, e, r);
    endtask
    // Flash word is presented before the controller reports it valid
    task automatic do_reset(input logic [31:0] pw);
        hresetn <= 1'b0;
        flash_init_done <= 1'b0;
        prot_word <= pw;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        flash_init_done <= 1'b1;
        repeat (4) @(negedge hclk);
    endtask
    task automatic count_pclk(input int k, output logic [31:0] cnt);
        cnt = 0;
        repeat (k) begin
            @(negedge hclk);
            cnt += pclk_en;
        end
    endtask
    task automatic wait_core(output int k);
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (core_clk_en !== 1'b1 && k < 200);
    endtask
    task automatic pulse(input int p);
        @(posedge hclk);
        ext_pin[p] <= 1'b1;
        repeat (3) @(posedge hclk);
        ext_pin[p] <= 1'b0;
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end

    initial begin
        for (int lv = 0; lv < 4; lv++) begin
            boot_override_pin <= 1'b0;
            do_reset(PATS[lv]);
            chk_out("protection", EXPS[lv], {debug_enable, serial_boot_programming,
                    serial_cmd_limited, sector0_locked, full_erase_only,
                    boot_override_en});
            chk_out("boot request", lv != 3, serial_boot_req);
            rd_chk("status level", OFS_STATUS, {29'h0, 1'b1, 2'(lv)});
        end
        $display("Protection levels done");
        boot_override_pin <= 1'b1;
        do_reset(32'h0);
        count_pclk(40, c);
        chk_out("reset ratio", 10, c);
        foreach (RATS[i]) begin
            wr(OFS_PCLK_DIV, i + 1);
            repeat (8) @(posedge hclk);
            count_pclk(40, c);
            chk_out("divided ticks", RATS[i], c);
        end
        $display("Divider done");
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d);
            rd_chk("register word", ROWS[i].a, ROWS[i].e);
        end
        @(negedge hclk);
        chk_out("map and enables", 17'h100A5, {vec_in_ram, periph_clk_en});
        $display("Register table done");
        wr(OFS_PWR_CTRL, 32'h1);
        repeat (3) @(negedge hclk);
        chk_out("idle", 19'h0052A, {periph_clk_en, core_clk_en, osc_en, pin_hold});
        count_pclk(8, c);
        chk_out("idle ticks", 32'h80000002, {pll_keep, c[30:0]});
        @(posedge hclk);
        irq_pending <= 1'b1;
        wait_core(n);
        irq_pending <= 1'b0;
        chk_out("idle wake", 1, n < 8);
        $display("Idle done");
        wr(OFS_PWR_CTRL, 32'h2);
        repeat (3) @(negedge hclk);
        chk_out("down", 3'b010, {osc_en, pin_hold, core_clk_en});
        pulse(1);
        repeat (10) @(negedge hclk);
        chk_out("masked line", 0, osc_en);
        pulse(4);
        wait_core(n);
        chk_out("wake wait", 1, n > WK && n < WK + 4);
        @(negedge hclk);
        chk_out("edge flags", 4'h3, ext_irq);
        rd_chk("mode cleared", OFS_PWR_CTRL, 0);
        wr(OFS_EX_FLAG, 32'hF);
        repeat (2) @(negedge hclk);
        chk_out("flags cleared", 0, ext_irq);
        wr(OFS_EX_MODE, 32'hB);
        ext_pin[6] <= 1'b1;
        repeat (6) @(negedge hclk);
        chk_out("level line", 4'h4, ext_irq);
        @(posedge hclk);
        ext_pin[6] <= 1'b0;
        repeat (6) @(negedge hclk);
        chk_out("level line", 0, ext_irq);
        $display("Power-down done");
        finish_test();
    end
endmodule
